// file: inc/pbcs_defines.vh
// Behaviour
// - Writing one to control bit 15 holds the digital core in reset and returns base registers 0x0 to 0xF to their defaults.
// - Control bit 14 loops MAC transmit data back to the MAC receive path; zero gives normal operation.
// - Control bit 11, or the power-down pin, puts the device in power-down; zero is normal mode.
// - Control bit 10 isolates the MAC interface so nothing is driven toward the MAC; zero is normal.
// - Control bit 6 is read-only and reads one for 1000 Mb/s.
// - The basic control register sits at index zero and resets to 0140h, with bits 8 and 6 reading one.
// - The basic status register sits at index one and resets to 0141h.
// - Status bit 8 is read-only one, advertising extended status in register 15.
// - Status bit 6 is read-only one, accepting management frames without preamble.
// - Status bit 2 reads one while the link is up and zero while it is down.
// - Status bit 0 is read-only one, showing extended register capabilities.
`ifndef PBCS_DEFINES_VH
`define PBCS_DEFINES_VH

`define PBCS_IDX_CTRL      6'h00
`define PBCS_IDX_STAT      6'h01
`define PBCS_IDX_IRQ_STAT  6'h10
`define PBCS_IDX_IRQ_MASK  6'h11
`define PBCS_IDX_LSB       2
`define PBCS_IDX_MSB       7
`define PBCS_STRB_LO       0
`define PBCS_STRB_HI       1

`define PBCS_CTRL_RST      15
`define PBCS_CTRL_LOOP     14
`define PBCS_CTRL_PDN      11
`define PBCS_CTRL_ISO      10
`define PBCS_CTRL_RESET    16'h0140
`define PBCS_CTRL_FIXED    16'h0140

`define PBCS_STAT_LINK     2
`define PBCS_STAT_RESET    16'h0141
`define PBCS_STAT_FIXED    16'h0141

`define PBCS_IRQ_W         3
`define PBCS_IRQ_LINK_UP   0
`define PBCS_IRQ_LINK_DN   1
`define PBCS_IRQ_RST_DONE  2
`define PBCS_IRQ_MASK_RST  3'h0

`define PBCS_CLK_PERIOD_NS 10
`define PBCS_SOFT_RST_NS   1000
`define PBCS_RST_CNT_LAST  16'h0001

`endif

// file: rtl/pbcs_regs.v
`timescale 1ns/1ps
`include "pbcs_defines.vh"

module pbcs_regs
#(
    parameter DW            = 8,
    parameter SOFT_RST_NS   = `PBCS_SOFT_RST_NS
)
(
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    input  wire [3:0]    pstrb,
    output wire [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    input  wire          link_up_pin,
    input  wire          power_down_pin,
    input  wire [DW-1:0] mac_txd,
    input  wire          mac_tx_en,
    output wire [DW-1:0] mac_rxd,
    output wire          mac_rx_dv,
    output wire          mac_rx_oe_n,
    input  wire [DW-1:0] line_rxd,
    input  wire          line_rx_dv,
    output wire [DW-1:0] line_txd,
    output wire          line_tx_en,
    output wire          core_rst_n,
    output wire          loopback_on,
    output wire          isolate_on,
    output wire          power_down_on,
    output wire          irq
);

localparam integer RST_CYC_RAW = SOFT_RST_NS / `PBCS_CLK_PERIOD_NS;
localparam integer RST_CYC     = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
localparam [15:0]  RST_LOAD    = RST_CYC[15:0];
// Control word as it stands after any reset
localparam [15:0]  CTRL_DEF    = `PBCS_CTRL_RESET;

localparam [1:0] ST_RUN   = 2'd0;
localparam [1:0] ST_RESET = 2'd1;
localparam [1:0] ST_DONE  = 2'd2;

// Pin inputs
wire [1:0] pins_sync;
wire       link_up_s;
wire       pdn_pin_s;

pbcs_sync
#(
    .W (2)
)
u_sync
(
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({power_down_pin, link_up_pin}),
    .sync_out (pins_sync)
);

assign link_up_s = pins_sync[0];
assign pdn_pin_s = pins_sync[1];

// Bus decode
wire [5:0] idx;
wire       addr_ok;
wire       hit_ctrl;
wire       hit_stat;
wire       hit_istat;
wire       hit_imask;
wire       mapped;
wire       setup_ph;
wire       wr_fire;
wire       wr_lo;
wire       wr_hi;
wire       ctrl_wr;
wire       istat_wr;
wire       imask_wr;

assign idx      = paddr[`PBCS_IDX_MSB:`PBCS_IDX_LSB];
assign addr_ok  = (paddr[`PBCS_IDX_LSB-1:0] == 2'h0);
assign hit_ctrl = addr_ok && (idx == `PBCS_IDX_CTRL);
assign hit_stat = addr_ok && (idx == `PBCS_IDX_STAT);
assign hit_istat = addr_ok && (idx == `PBCS_IDX_IRQ_STAT);
assign hit_imask = addr_ok && (idx == `PBCS_IDX_IRQ_MASK);
assign mapped   = hit_ctrl || hit_stat || hit_istat || hit_imask;
assign setup_ph = psel && !penable;
assign wr_fire  = psel && penable && pwrite && mapped;
assign wr_lo    = pstrb[`PBCS_STRB_LO];
assign wr_hi    = pstrb[`PBCS_STRB_HI];
assign ctrl_wr  = wr_fire && hit_ctrl && wr_hi;
assign istat_wr = wr_fire && hit_istat && wr_lo;
assign imask_wr = wr_fire && hit_imask && wr_lo;

assign pready  = 1'b1;
assign pslverr = psel && penable && !mapped;

// Control state
reg        loop_ff;
reg        pdn_ff;
reg        iso_ff;
reg [1:0]  state_ff;
reg [15:0] rst_cnt_ff;
reg        link_prev_ff;
reg [`PBCS_IRQ_W-1:0] irq_stat_ff;
reg [`PBCS_IRQ_W-1:0] irq_mask_ff;
reg [31:0] prdata_ff;

reg        nxt_loop;
reg        nxt_pdn;
reg        nxt_iso;
reg [1:0]  nxt_state;
reg [15:0] nxt_rst_cnt;
reg        rst_done_evt;

wire       busy;
wire       pdn_eff;
wire       soft_rst_req;

assign busy         = (state_ff == ST_RESET);
assign pdn_eff      = pdn_ff || pdn_pin_s;
assign soft_rst_req = ctrl_wr && pwdata[`PBCS_CTRL_RST] && !busy;

always @*
begin
    nxt_loop     = loop_ff;
    nxt_pdn      = pdn_ff;
    nxt_iso      = iso_ff;
    nxt_state    = state_ff;
    nxt_rst_cnt  = rst_cnt_ff;
    rst_done_evt = 1'b0;
    case (state_ff)
        ST_RUN:
        begin
            if (soft_rst_req)
            begin
                // Base registers back to defaults, core held in reset
                nxt_loop    = CTRL_DEF[`PBCS_CTRL_LOOP];
                nxt_pdn     = CTRL_DEF[`PBCS_CTRL_PDN];
                nxt_iso     = CTRL_DEF[`PBCS_CTRL_ISO];
                nxt_rst_cnt = RST_LOAD;
                nxt_state   = ST_RESET;
            end
            else if (ctrl_wr)
            begin
                nxt_loop = pwdata[`PBCS_CTRL_LOOP];
                nxt_pdn  = pwdata[`PBCS_CTRL_PDN];
                nxt_iso  = pwdata[`PBCS_CTRL_ISO];
            end
        end
        ST_RESET:
        begin
            // Control writes are ignored while the core is in reset
            if (rst_cnt_ff == `PBCS_RST_CNT_LAST)
            begin
                nxt_rst_cnt = 16'h0000;
                nxt_state   = ST_DONE;
            end
            else
            begin
                nxt_rst_cnt = rst_cnt_ff - 16'h0001;
            end
        end
        ST_DONE:
        begin
            // Reset bit self-clears here
            rst_done_evt = 1'b1;
            nxt_state    = ST_RUN;
        end
        default:
        begin
            nxt_state = ST_RUN;
        end
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        loop_ff    <= CTRL_DEF[`PBCS_CTRL_LOOP];
        pdn_ff     <= CTRL_DEF[`PBCS_CTRL_PDN];
        iso_ff     <= CTRL_DEF[`PBCS_CTRL_ISO];
        state_ff   <= ST_RUN;
        rst_cnt_ff <= 16'h0000;
    end
    else
    begin
        loop_ff    <= nxt_loop;
        pdn_ff     <= nxt_pdn;
        iso_ff     <= nxt_iso;
        state_ff   <= nxt_state;
        rst_cnt_ff <= nxt_rst_cnt;
    end
end

// Interrupt status, set wins over write-one-to-clear
// Soft reset leaves these alone: they sit above the base register range
wire [`PBCS_IRQ_W-1:0] irq_evt;
wire [`PBCS_IRQ_W-1:0] irq_clr;

assign irq_evt[`PBCS_IRQ_LINK_UP]  = link_up_s && !link_prev_ff;
assign irq_evt[`PBCS_IRQ_LINK_DN]  = !link_up_s && link_prev_ff;
assign irq_evt[`PBCS_IRQ_RST_DONE] = rst_done_evt;
assign irq_clr = istat_wr ? pwdata[`PBCS_IRQ_W-1:0]
                          : {`PBCS_IRQ_W{1'b0}};

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        link_prev_ff <= 1'b0;
        irq_stat_ff  <= {`PBCS_IRQ_W{1'b0}};
        irq_mask_ff  <= `PBCS_IRQ_MASK_RST;
    end
    else
    begin
        link_prev_ff <= link_up_s;
        irq_stat_ff  <= (irq_stat_ff & ~irq_clr) | irq_evt;
        if (imask_wr)
        begin
            irq_mask_ff <= pwdata[`PBCS_IRQ_W-1:0];
        end
    end
end

assign irq = |(irq_stat_ff & irq_mask_ff);

// Read data
reg  [15:0] ctrl_rd;
reg  [15:0] stat_rd;
reg  [31:0] rd_mux;

always @*
begin
    ctrl_rd = `PBCS_CTRL_FIXED;
    ctrl_rd[`PBCS_CTRL_RST]  = busy;
    ctrl_rd[`PBCS_CTRL_LOOP] = loop_ff;
    ctrl_rd[`PBCS_CTRL_PDN]  = pdn_eff;
    ctrl_rd[`PBCS_CTRL_ISO]  = iso_ff;
    stat_rd = `PBCS_STAT_FIXED;
    stat_rd[`PBCS_STAT_LINK] = link_up_s;
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
    begin
        rd_mux[15:0] = ctrl_rd;
    end
    else if (hit_stat)
    begin
        rd_mux[15:0] = stat_rd;
    end
    else if (hit_istat)
    begin
        rd_mux[`PBCS_IRQ_W-1:0] = irq_stat_ff;
    end
    else if (hit_imask)
    begin
        rd_mux[`PBCS_IRQ_W-1:0] = irq_mask_ff;
    end
end

// Read data captured in the setup cycle, shown in the access cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata_ff <= 32'h0000_0000;
    end
    else if (setup_ph)
    begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
    end
end

assign prdata = prdata_ff;

// MAC and line datapath
reg [DW-1:0] mac_rxd_ff;
reg          mac_rx_dv_ff;
reg          mac_rx_oe_n_ff;
reg [DW-1:0] line_txd_ff;
reg          line_tx_en_ff;

wire         core_quiet;

assign core_quiet = busy || pdn_eff;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        mac_rxd_ff     <= {DW{1'b0}};
        mac_rx_dv_ff   <= 1'b0;
        mac_rx_oe_n_ff <= 1'b1;
        line_txd_ff    <= {DW{1'b0}};
        line_tx_en_ff  <= 1'b0;
    end
    else
    begin
        mac_rx_oe_n_ff <= iso_ff;
        if (iso_ff || core_quiet)
        begin
            mac_rxd_ff   <= {DW{1'b0}};
            mac_rx_dv_ff <= 1'b0;
        end
        else if (loop_ff)
        begin
            mac_rxd_ff   <= mac_txd;
            mac_rx_dv_ff <= mac_tx_en;
        end
        else
        begin
            mac_rxd_ff   <= line_rxd;
            mac_rx_dv_ff <= line_rx_dv;
        end
        // Loopback keeps transmit data off the line
        if (core_quiet || loop_ff)
        begin
            line_txd_ff   <= {DW{1'b0}};
            line_tx_en_ff <= 1'b0;
        end
        else
        begin
            line_txd_ff   <= mac_txd;
            line_tx_en_ff <= mac_tx_en;
        end
    end
end

assign mac_rxd       = mac_rxd_ff;
assign mac_rx_dv     = mac_rx_dv_ff;
assign mac_rx_oe_n   = mac_rx_oe_n_ff;
assign line_txd      = line_txd_ff;
assign line_tx_en    = line_tx_en_ff;
assign core_rst_n    = !busy;
assign loopback_on   = loop_ff;
assign isolate_on    = iso_ff;
assign power_down_on = pdn_eff;

endmodule

// file: rtl/pbcs_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for pin levels
module pbcs_sync
#(
    parameter W = 2
)
(
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

reg [W-1:0] meta_ff;
reg [W-1:0] sync_ff;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta_ff <= {W{1'b0}};
        sync_ff <= {W{1'b0}};
    end
    else
    begin
        meta_ff <= async_in;
        sync_ff <= meta_ff;
    end
end

assign sync_out = sync_ff;

endmodule

// file: testbench/pbcs_host.sv
`timescale 1ns/1ps
module pbcs_host
(
    input  wire        pclk,
    input  wire        pready,
    output reg         psel = 1'b0,
    output reg         penable = 1'b0,
    output reg         pwrite = 1'b0,
    output reg  [7:0]  paddr = 8'h00,
    output reg  [31:0] pwdata = 32'h0,
    output reg  [3:0]  pstrb = 4'hf,
    output reg         hung = 1'b0
);
    task xfer(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (!pready && n < 50)
            begin
                n = n + 1;
                @(posedge pclk);
            end
            if (!pready)
                hung <= 1'b1;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule

// file: testbench/pbcs_regs_asserts.sv
`timescale 1ns/1ps
module pbcs_regs_asserts
#(
    parameter DW          = 8,
    parameter SOFT_RST_NS = 1000
)
(
    input wire          pclk,
    input wire          presetn,
    input wire          psel,
    input wire          penable,
    input wire          pwrite,
    input wire [7:0]    paddr,
    input wire [31:0]   prdata,
    input wire          pslverr,
    input wire [DW-1:0] mac_txd,
    input wire [DW-1:0] mac_rxd,
    input wire          mac_rx_oe_n,
    input wire          core_rst_n,
    input wire          loopback_on,
    input wire          isolate_on,
    input wire          power_down_on
);
    localparam RST_CYC = SOFT_RST_NS / 10;
    reg  [15:0] low_cnt_ff;
    wire [15:0] nxt_low_cnt = core_rst_n ? 16'h0 : low_cnt_ff + 16'h1;
    wire        rd_acc = psel && penable && !pwrite;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            low_cnt_ff <= 16'h0;
        else
            low_cnt_ff <= nxt_low_cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_align; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    a_align: assert property (p_align) else $error("misaligned not refused");
    property p_errdat; pslverr |-> prdata == 32'h0; endproperty
    a_errdat: assert property (p_errdat) else $error("error read data");
    property p_upper; rd_acc |-> prdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper half set");
    property p_ctrl; rd_acc && paddr == 8'h00 |-> (prdata & 32'h33ff) == 32'h140; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control fixed bits");
    property p_stat; rd_acc && paddr == 8'h04 |-> (prdata & 32'hfffb) == 32'h141; endproperty
    a_stat: assert property (p_stat) else $error("status fixed bits");
    property p_srst; $rose(core_rst_n) |-> low_cnt_ff == RST_CYC; endproperty
    a_srst: assert property (p_srst) else $error("soft reset length");
    property p_loop;
        (loopback_on && !isolate_on && !power_down_on && core_rst_n) [*2]
        |-> mac_rxd == $past(mac_txd);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback data");
    property p_iso; isolate_on [*2] |-> mac_rx_oe_n && mac_rxd == 0; endproperty
    a_iso: assert property (p_iso) else $error("isolate drives mac");
endmodule
bind pbcs_regs pbcs_regs_asserts #(.DW(DW), .SOFT_RST_NS(SOFT_RST_NS)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .mac_txd(mac_txd),
    .mac_rxd(mac_rxd), .mac_rx_oe_n(mac_rx_oe_n), .core_rst_n(core_rst_n),
    .loopback_on(loopback_on), .isolate_on(isolate_on), .power_down_on(power_down_on));

// file: testbench/phy_basic_ctrl_status_regs_bench.sv
`timescale 1ns/1ps
module phy_basic_ctrl_status_regs_bench;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         link_up_pin = 1'b0;
    reg         power_down_pin = 1'b0;
    reg  [31:0] rs = 32'd26;
    reg  [7:0]  mac_txd = 8'h00;
    reg         mac_tx_en = 1'b0;
    reg  [7:0]  line_rxd = 8'h00;
    reg         line_rx_dv = 1'b0;
    wire        psel, penable, pwrite, pready, pslverr, irq, hung, lb, iso, pdn;
    wire [7:0]  paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0]  pstrb;
    wire [7:0]  mac_rxd, line_txd;
    wire        mac_rx_dv, mac_rx_oe_n, line_tx_en, core_rst_n;
    integer     err_total = 0;
    integer     n_compared = 0;
    reg  [31:0] expq[$];
    always #5 pclk = ~pclk;
    pbcs_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .hung(hung));
    pbcs_regs #(.SOFT_RST_NS(50)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up_pin(link_up_pin),
        .power_down_pin(power_down_pin), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en),
        .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv), .mac_rx_oe_n(mac_rx_oe_n),
        .line_rxd(line_rxd), .line_rx_dv(line_rx_dv), .line_txd(line_txd),
        .line_tx_en(line_tx_en), .core_rst_n(core_rst_n),
        .loopback_on(lb), .isolate_on(iso), .power_down_on(pdn), .irq(irq));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (expq.size() != 0)
                err_total = err_total + 1;
            $display("Compared %0d, errors %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        host.xfer(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            expq.push_back(e);
            host.xfer(1'b0, a, 32'h0);
        end
    endtask
    task irq_is(input v);
        begin
            @(negedge pclk);
            chk({31'h0, irq}, {31'h0, v});
        end
    endtask
    // Writes a control word, then checks one registered datapath cycle
    task path_is(input [15:0] c);
        reg [8:0] tx;
        reg [8:0] rx;
        begin
            wr(8'h00, {16'h0, c});
            repeat (2) @(negedge pclk);
            tx = {mac_tx_en, mac_txd};
            rx = {line_rx_dv, line_rxd};
            @(negedge pclk);
            chk({23'h0, mac_rx_dv, mac_rxd}, (c[10] | c[11]) ? 32'h0 : {23'h0, c[14] ? tx : rx});
            chk({23'h0, line_tx_en, line_txd}, (c[11] | c[14]) ? 32'h0 : {23'h0, tx});
            chk({31'h0, mac_rx_oe_n}, {31'h0, c[10]});
            @(posedge pclk);
        end
    endtask
    always @(posedge pclk)
    begin
        rs <= xs(rs);
        mac_txd <= rs[7:0];
        mac_tx_en <= rs[8];
        line_rxd <= rs[15:8];
        line_rx_dv <= rs[16];
        if (psel && penable && pready && !pwrite && expq.size() != 0)
            chk(prdata, expq.pop_front());
    end
    always @(posedge hung)
    begin
        err_total = err_total + 1;
        report_and_stop;
    end
    initial
    begin
        #500000;
        err_total = err_total + 1;
        report_and_stop;
    end
    initial
    begin : main
        integer i;
        reg [31:0] d;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h140);
        rd(8'h04, 32'h141);
        wr(8'h44, 32'h7);
        link_up_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        irq_is(1'b1);
        rd(8'h04, 32'h145);
        rd(8'h40, 32'h1);
        wr(8'h40, 32'h1);
        irq_is(1'b0);
        wr(8'h04, 32'hffff);
        rd(8'h04, 32'h145);
        rd(8'h08, 32'h0);
        rd(8'h02, 32'h0);
        for (i = 0; i < 8; i = i + 1)
        begin
            d = rs & 32'h7fff;
            wr(8'h00, d);
            rd(8'h00, 32'h140 | (d & 32'h4c00));
            @(negedge pclk);
            chk({29'h0, lb, iso, pdn}, {29'h0, d[14], d[10], d[11]});
        end
        wr(8'h00, 32'h0);
        path_is(16'h0000);
        path_is(16'h4000);
        path_is(16'h0400);
        path_is(16'h0800);
        path_is(16'h0000);
        power_down_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(8'h00, 32'h940);
        power_down_pin <= 1'b0;
        wr(8'h00, 32'h4c00);
        wr(8'h00, 32'h8000);
        @(negedge pclk);
        chk({31'h0, core_rst_n}, 32'h0);
        rd(8'h00, 32'h8140);
        repeat (10) @(posedge pclk);
        rd(8'h00, 32'h140);
        rd(8'h40, 32'h4);
        irq_is(1'b1);
        wr(8'h44, 32'h0);
        irq_is(1'b0);
        wr(8'h40, 32'h4);
        link_up_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        rd(8'h04, 32'h141);
        rd(8'h40, 32'h2);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h40, 32'h0);
        rd(8'h00, 32'h140);
        repeat (3) @(posedge pclk);
        report_and_stop;
    end
endmodule
